/* File: hw/port_pin_regs.svh */
// Offsets, field positions and reset values for the port pin interrupt and pull-up banks.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef PORT_PIN_REGS_SVH
`define PORT_PIN_REGS_SVH

`define PORT_COUNT 7
`define PORT_PINS 8
`define PORT0_BASE_ADDR 32'h4007_0000
`define PORT_BANK_STRIDE 12'h100
`define PORT_BANK_LSB 8
`define PORT_BANK_MSB 10
`define PORT_ADDR_MSB 11
`define OFS_PIN_MODE_HIGH_HALF 8'h00
`define OFS_PIN_MODE_LOW_HALF 8'h04
`define OFS_PIN_EDGE_SELECT 8'h08
`define OFS_PIN_IRQ_ENABLE 8'h0C
`define OFS_PIN_IRQ_PENDING 8'h10
`define OFS_PIN_PULLUP_ENABLE 8'h14
`define PIN_FIELD_MSB 7
`define PIN_RSVD_ZERO 24'h00_0000
`define PIN_REG_RESET 8'h00
`define MODE_FIELD_W 2

`endif

/* File: hw/port_pin_pkg.sv */
// Types shared by the port pin interrupt and pull-up logic.
// Assumes port_pin_regs.svh is compiled alongside for the numeric constants.
package port_pin_pkg;

  typedef enum logic [1:0] {
    MODE_INPUT = 2'b00,
    MODE_PUSH_PULL = 2'b01,
    MODE_OPEN_DRAIN = 2'b10,
    MODE_UNUSED = 2'b11
  } pin_mode_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_IRQ_ENABLE = 2'b01,
    SEL_IRQ_PENDING = 2'b10,
    SEL_PULLUP_ENABLE = 2'b11
  } reg_sel_t;

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [1:0] warm;
  } edge_state_t;

  typedef struct packed {
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
  } drive_state_t;

  typedef struct packed {
    logic [6:0][7:0] irq_enable;
    logic [6:0][7:0] irq_pending;
    logic [6:0][7:0] pullup_enable;
    logic [31:0] rdata;
    logic [6:0] port_irq;
    logic irq;
  } bank_state_t;

endpackage : port_pin_pkg

/* File: hw/port_edge_detect.sv */
// Pin synchroniser and edge detector for one eight-pin port.
// Assumes pin_i is asynchronous and edge_sel comes from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module port_edge_detect
  import port_pin_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Pins and polarity
  input wire logic [7:0] pin_i,
  input wire logic [7:0] edge_sel,
  // Detected edge of the selected polarity
  output logic [7:0] edge_hit
);

  edge_state_t st_r;
  edge_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pin_i;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    st_nxt.warm = (st_r.warm == 2'b11) ? 2'b11 : st_r.warm + 2'b01;
    // Only the second stage and its delayed copy are compared
    edge_hit = (edge_sel & st_r.sync2 & ~st_r.prev) |
               (~edge_sel & ~st_r.sync2 & st_r.prev); // RULE10
    // Held off until prev holds a real sample, else an idle-high pin fakes a rise
    if (st_r.warm != 2'b11) begin
      edge_hit = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : port_edge_detect

`default_nettype wire

/* File: hw/port_pin_drive.sv */
// Pin driver for one eight-pin port, steered by the two-bit mode of each pin.
// Assumes mode and out_data come from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none

`include "port_pin_regs.svh"

module port_pin_drive
  import port_pin_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Mode fields and output data
  input wire logic [15:0] mode,
  input wire logic [7:0] out_data,
  // Pad drive, registered
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe
);

  drive_state_t st_r;
  drive_state_t st_nxt;

  function automatic pin_mode_t mode_of(input logic [15:0] m, input int n);
    return pin_mode_t'(m[n*`MODE_FIELD_W +: `MODE_FIELD_W]);
  endfunction : mode_of

  always_comb begin
    st_nxt = st_r;
    for (int n = 0; n < `PORT_PINS; n++) begin
      unique case (mode_of(mode, n))
        MODE_PUSH_PULL: begin
          st_nxt.pin_o[n] = out_data[n]; // RULE11
          st_nxt.pin_oe[n] = 1'b1;
        end
        MODE_OPEN_DRAIN: begin
          // Pulls low only; a one leaves the pad to the pull-up
          st_nxt.pin_o[n] = 1'b0; // RULE11
          st_nxt.pin_oe[n] = ~out_data[n];
        end
        MODE_INPUT, MODE_UNUSED: begin
          st_nxt.pin_o[n] = 1'b0; // RULE11
          st_nxt.pin_oe[n] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_o = st_r.pin_o;
  assign pin_oe = st_r.pin_oe;

endmodule : port_pin_drive

`default_nettype wire

/* File: hw/port_pin_irq_pullup_regs.sv */
// Interrupt enable, pending and pull-up registers for seven eight-pin ports.
// Assumes a plain register port on sys_clk; edge select, modes and pin data
// come from neighbouring registers on the same clock; pins are asynchronous.
//
// Functional notes
// RULE1: Seven banks, port zero lowest, each next bank 0x100 higher.
// RULE2: Interrupt enable register at bank offset 0x000C, resets to zero.
// RULE3: Enable bit n allows pin n interrupts when one; read and write.
// RULE4: Interrupt pending register at bank offset 0x0010, resets to zero.
// RULE5: Pending bit n reads one while pin n has a pending interrupt.
// RULE6: Writing zero clears a pending bit; software clears serviced pins so.
// RULE7: Pull-up enable register at bank offset 0x0014, resets to zero.
// RULE8: Pull-up bit n drives pin n pull-up control; read and write.
// RULE9: Bits 31 to 8 of these registers are reserved and read zero.
// RULE10: Edge select bit picks falling (zero) or rising (one) edge per pin.
// RULE11: Two-bit mode: 00 input, 01 push-pull, 10 open-drain low only.
// RULE12: Selected synchronised edge on enabled pin sets pending; interrupt while enabled pending.
// RULE13: Writing one keeps pending; a same-cycle edge beats a clearing write.
`timescale 1ns/1ps
`default_nettype none

`include "port_pin_regs.svh"

module port_pin_irq_pullup_regs
  import port_pin_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port, byte offset from the port zero bank
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  // Neighbouring registers
  input wire logic [6:0][7:0] pin_edge_select,
  input wire logic [6:0][15:0] pin_mode_field,
  input wire logic [6:0][7:0] pin_out_data,
  // Pads
  input wire logic [6:0][7:0] pin_i,
  output logic [6:0][7:0] pin_o,
  output logic [6:0][7:0] pin_oe,
  output logic [6:0][7:0] pullup_o,
  // Interrupts
  output logic [6:0] port_irq,
  output logic irq
);

  bank_state_t st_r;
  bank_state_t st_nxt;
  logic [6:0][7:0] edge_hit;
  logic [2:0] bank;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;

  // Banks past port six and misaligned words decode to nothing
  function automatic reg_sel_t reg_decode(input logic [11:0] a);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (!a[`PORT_ADDR_MSB] && (a[`PORT_BANK_MSB:`PORT_BANK_LSB] < 3'(`PORT_COUNT))) begin // RULE1
      unique case (a[7:0])
        `OFS_PIN_IRQ_ENABLE: sel = SEL_IRQ_ENABLE; // RULE2
        `OFS_PIN_IRQ_PENDING: sel = SEL_IRQ_PENDING; // RULE4
        `OFS_PIN_PULLUP_ENABLE: sel = SEL_PULLUP_ENABLE; // RULE7
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction : reg_decode

  genvar gp;
  generate
    for (gp = 0; gp < `PORT_COUNT; gp++) begin : g_port
      port_edge_detect u_edge (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_i(pin_i[gp]),
        .edge_sel(pin_edge_select[gp]),
        .edge_hit(edge_hit[gp])
      );
      port_pin_drive u_drive (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .mode(pin_mode_field[gp]),
        .out_data(pin_out_data[gp]),
        .pin_o(pin_o[gp]),
        .pin_oe(pin_oe[gp])
      );
    end
  endgenerate

  always_comb begin
    logic [7:0] set_bits;
    set_bits = `PIN_REG_RESET;
    st_nxt = st_r;
    bank = addr[`PORT_BANK_MSB:`PORT_BANK_LSB];
    wr_sel = wr_stb ? reg_decode(addr) : SEL_NONE;
    rd_sel = rd_stb ? reg_decode(addr) : SEL_NONE;

    // Register writes; bits above the pin field are dropped
    for (int p = 0; p < `PORT_COUNT; p++) begin
      if (bank == 3'(p)) begin
        if (wr_sel == SEL_IRQ_ENABLE) begin
          st_nxt.irq_enable[p] = wdata[`PIN_FIELD_MSB:0]; // RULE3
        end
        if (wr_sel == SEL_PULLUP_ENABLE) begin
          st_nxt.pullup_enable[p] = wdata[`PIN_FIELD_MSB:0]; // RULE8
        end
        if (wr_sel == SEL_IRQ_PENDING) begin
          // Zero clears, one keeps
          st_nxt.irq_pending[p] = st_r.irq_pending[p] & wdata[`PIN_FIELD_MSB:0]; // RULE6
        end
      end
      // Edge set applied after the write so it wins over a clear
      set_bits = edge_hit[p] & st_r.irq_enable[p]; // RULE12
      st_nxt.irq_pending[p] = st_nxt.irq_pending[p] | set_bits; // RULE13
      st_nxt.port_irq[p] = |(st_nxt.irq_pending[p] & st_nxt.irq_enable[p]); // RULE12
    end
    st_nxt.irq = |st_nxt.port_irq;

    // Read data stands for exactly the cycle after the strobe
    st_nxt.rdata = 32'h0000_0000;
    unique case (rd_sel)
      SEL_IRQ_ENABLE: st_nxt.rdata = {`PIN_RSVD_ZERO, st_r.irq_enable[bank]}; // RULE9
      SEL_IRQ_PENDING: st_nxt.rdata = {`PIN_RSVD_ZERO, st_r.irq_pending[bank]}; // RULE5
      SEL_PULLUP_ENABLE: st_nxt.rdata = {`PIN_RSVD_ZERO, st_r.pullup_enable[bank]}; // RULE9
      SEL_NONE: st_nxt.rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0; // RULE2
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign pullup_o = st_r.pullup_enable; // RULE8
  assign port_irq = st_r.port_irq;
  assign irq = st_r.irq;

endmodule : port_pin_irq_pullup_regs

`default_nettype wire

/* File: bench/pin_regs_checker_assertions.sv */
// Port-level checks for the pin interrupt and pull-up registers.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pin_regs_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  // Pads and interrupts
  input wire logic [6:0][7:0] pin_i,
  input wire logic [6:0][7:0] pullup_o,
  input wire logic [6:0] port_irq,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Pin change three edges back, as the sync chain delays it
  sequence pin_moved;
    $past(pin_i[2], 3) != $past(pin_i[2], 4);
  endsequence
  rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data without a read");
  rsvd_zero_a: assert property ($past(rd_stb) |-> rdata[31:8] == 24'h0)
    else $error("reserved bits set");
  unmapped_read_a: assert property ($past(rd_stb && (addr[11] || addr[10:8] == 3'h7)) |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  pullup_write_a: assert property (wr_stb && addr == 12'h014 |=> pullup_o[0] == $past(wdata[7:0]))
    else $error("pull-up not written");
  pullup_read_a: assert property ($past(rd_stb && addr == 12'h014) |-> rdata[7:0] == pullup_o[0])
    else $error("pull-up readback differs");
  irq_combine_a: assert property (irq == |port_irq)
    else $error("irq not the port OR");
  irq_masked_a: assert property (wr_stb && addr == 12'h20C && wdata[7:0] == 8'h00 |=> !port_irq[2])
    else $error("irq despite zero enable");
  irq_cause_a: assert property ($rose(port_irq[2]) |-> $past(wr_stb) or pin_moved)
    else $error("irq without cause");
endmodule : pin_regs_checker
bind port_pin_irq_pullup_regs pin_regs_checker chk (.sys_clk, .sys_rst, .addr, .wdata, .wr_stb,
  .rd_stb, .rdata, .pin_i, .pullup_o, .port_irq, .irq);
`default_nettype wire

/* File: bench/pin_board.sv */
// Board model of the pads: external drivers, pull-ups, floating lines.
// Assumes pad controls come from the design.
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  // Clock
  input wire logic sys_clk,
  // Design pad controls
  input wire logic [6:0][7:0] pin_o,
  input wire logic [6:0][7:0] pin_oe,
  input wire logic [6:0][7:0] pullup_o,
  // Board drivers
  input wire logic [6:0][7:0] ext_v,
  input wire logic [6:0][7:0] ext_en,
  // Resolved level
  output logic [6:0][7:0] pad
);
  // Undriven pads without the pull-up enabled toggle so no settled unknown hides a fault
  logic [6:0][7:0] flt = '0;
  always @(posedge sys_clk) flt <= ~flt;
  assign pad = pin_oe & pin_o | ~pin_oe & (ext_en & ext_v | ~ext_en & (pullup_o | flt));
endmodule : pin_board
`default_nettype wire

/* File: bench/test_port_pin_irq_pullup_regs.sv */
// Bench for the pin interrupt and pull-up registers.
// Assumes design, checker and pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module test_port_pin_irq_pullup_regs;
  logic sys_clk = 1'b0, sys_rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, irq;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [6:0][7:0] esel = '0, odat = '0, ext_v = '0, ext_en = '1, pin_i, pin_o, pin_oe, pullup_o;
  logic [6:0][15:0] mode = '0;
  logic [6:0] port_irq;
  int n_errors = 0, samples_checked = 0;
  pin_board board (.sys_clk, .pin_o, .pin_oe, .pullup_o, .ext_v, .ext_en, .pad(pin_i));
  port_pin_irq_pullup_regs uut (.sys_clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .pin_edge_select(esel), .pin_mode_field(mode), .pin_out_data(odat), .pin_i, .pin_o,
    .pin_oe, .pullup_o, .port_irq, .irq);
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rd
  task automatic stop_test;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Bank 7 is unmapped, so the loops also cover refusal
    for (int b = 0; b < 8; b++) begin
      rd({1'b0, b[2:0], 8'h0C}, 32'h0);
      rd({1'b0, b[2:0], 8'h10}, 32'h0);
      rd({1'b0, b[2:0], 8'h14}, 32'h0);
      wr({1'b0, b[2:0], 8'h0C}, 32'hFFFF_FF30 + b);
      wr({1'b0, b[2:0], 8'h14}, 32'hFFFF_FF0F - b);
      wr({1'b0, b[2:0], 8'h10}, 32'hFF);
    end
    for (int b = 0; b < 8; b++) begin
      rd({1'b0, b[2:0], 8'h0C}, b < 7 ? 32'h30 + b : 32'h0);
      rd({1'b0, b[2:0], 8'h14}, b < 7 ? 32'h0F - b : 32'h0);
      rd({1'b0, b[2:0], 8'h10}, 32'h0);
      if (b < 7) `CHK(pullup_o[b], 8'h0F - b[7:0])
    end
    wr(12'h80C, 32'h0);
    rd(12'h80C, 32'h0);
    rd(12'h00C, 32'h30);
    rd(12'h008, 32'h0);
    wr(12'h20C, 32'h03);
    esel[2] <= 8'hFD;
    ext_v[2] <= 8'h07;
    for (int k = 0; irq !== 1'b1; k++) begin
      if (k == 8) begin n_errors++; stop_test(); end
      @(posedge sys_clk);
      #1;
    end
    `CHK(port_irq, 7'h04)
    rd(12'h210, 32'h01);
    @(posedge sys_clk);
    ext_v[2] <= 8'h00;
    repeat (4) @(posedge sys_clk);
    rd(12'h210, 32'h03);
    wr(12'h210, 32'hFE);
    rd(12'h210, 32'h02);
    wr(12'h20C, 32'h00);
    #1 `CHK(irq, 1'b0)
    rd(12'h210, 32'h02);
    // Clearing write lands on the edge that sets pin 2
    wr(12'h20C, 32'h04);
    ext_v[2] <= 8'h04;
    @(posedge sys_clk);
    wr(12'h210, 32'h00);
    rd(12'h210, 32'h04);
    `CHK(irq, 1'b1)
    @(posedge sys_clk);
    mode[3] <= 16'h0029;
    odat[3] <= 8'h05;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(pin_oe[3], 8'h03)
    `CHK(pin_o[3], 8'h01)
    // Mid-run reset; pin 2 idles high, so its release must not look like a rise
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wr(12'h20C, 32'h04);
    rd(12'h210, 32'h0);
    rd(12'h314, 32'h0);
    `CHK(irq, 1'b0)
    stop_test();
  end
endmodule : test_port_pin_irq_pullup_regs
`default_nettype wire
